// ==== verilog/pwrst_regs.sv ====
`timescale 1ns/1ps
`include "pwrst_consts.svh"

module pwrst_regs
	import pwrst_pkg::*;
(
	input  wire logic          clock_in,                // Core clock, 25 MHz
	input  wire logic          rstn_in,                 // Async reset, active low
	input  wire logic [7:0]    reg_addr_in,             // Subaddress from host interface
	input  wire logic [7:0]    reg_wdata_in,            // Write data
	input  wire logic          reg_wr_in,               // Write strobe, one cycle
	input  wire logic          reg_rd_in,               // Read strobe, one cycle
	input  wire logic          powerdown_pin_in,        // Powerdown pin, async
	input  wire logic          reacquire_pin_in,        // Reacquire pin, async
	input  wire logic          lock_in,                 // Decoder in lock
	input  wire logic          subcarrier_lock_in,      // Subcarrier locked
	input  wire logic          field_50hz_in,           // 50 Hz field rate detected
	input  wire logic          adc_underflow_in,        // ADC underflow condition
	input  wire logic          adc_overflow_in,         // ADC overflow condition
	input  wire logic          white_peak_in,           // White peak limiting active
	input  wire logic          colour_kill_in,          // Colour kill active
	input  wire pwrst_td_cfg_t td_cfg_in,               // Decimation settings
	input  wire logic          field_start_in,          // Pulse at each field start
	input  wire logic          field_odd_in,            // Parity of starting field
	output logic [7:0]         reg_rdata_out,           // Read data, valid after strobe
	output logic [1:0]         power_save_select_out,   // Current power mode field
	output logic               adc_main_enable_out,     // Composite ADC powered
	output logic               adc_aux_enable_out,      // Second ADC powered
	output logic               analog_enable_out,       // Analog front end powered
	output logic               core_powerdown_out,      // Digital core powered down
	output logic               pads_disable_out,        // Input pads disabled
	output logic               clock_stop_out,          // Core clock stopped
	output logic               reference_sleep_out,     // Analog reference asleep
	output logic               clock_generator_sleep_out, // Line clock generator asleep
	output logic               reacquire_out,           // Reacquire pulse
	output logic               core_reset_out,          // Core reset pulse
	output logic               host_if_reset_out,       // Host interface reset pulse
	output logic               field_valid_out          // Current field is output
);

	pwrst_pm_t     pm_reg;
	pwrst_status_t status_reg;
	logic          lost_lock_reg;
	logic [1:0]    pd_sync_reg;
	logic [1:0]    rq_sync_reg;
	logic          rq_prev_reg;
	logic          pm_wr;
	logic          status_rd;
	logic          powerdown_eff;
	logic          lost_event;

	assign pm_wr      = reg_wr_in && (reg_addr_in == `PWRST_PM_ADDR);
	assign status_rd  = reg_rd_in && (reg_addr_in == `PWRST_STATUS_ADDR);
	assign lost_event = !lock_in;

	// Pins cross into the clock domain through two flops
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pd_sync_reg <= 2'h0;
			rq_sync_reg <= 2'h0;
			rq_prev_reg <= 1'b0;
		end
		else
		begin
			pd_sync_reg <= {pd_sync_reg[0], powerdown_pin_in};
			rq_sync_reg <= {rq_sync_reg[0], reacquire_pin_in};
			rq_prev_reg <= rq_sync_reg[1];
		end
	end

	// Power management register; writes to the status address land nowhere
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			pm_reg <= pwrst_pm_t'(`PWRST_PM_RESET);
		else if (pm_wr)
			pm_reg <= pwrst_pm_t'(reg_wdata_in);
		else
		begin
			pm_reg.timing_reacquire <= 1'b0;
			pm_reg.core_reset       <= 1'b0;
		end
	end

	// Bit priority decides whether the pin or the register bit wins
	assign powerdown_eff = pm_reg.powerdown_priority ? pm_reg.full_powerdown
		: pd_sync_reg[1];

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			core_powerdown_out <= 1'b0;
			pads_disable_out   <= 1'b0;
			clock_stop_out     <= 1'b0;
		end
		else
		begin
			core_powerdown_out <= powerdown_eff;
			pads_disable_out   <= powerdown_eff;
			clock_stop_out     <= powerdown_eff;
		end
	end

	// Power mode decode
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			power_save_select_out <= 2'h0;
			adc_main_enable_out   <= 1'b1;
			adc_aux_enable_out    <= 1'b1;
			analog_enable_out     <= 1'b1;
		end
		else
		begin
			power_save_select_out <= pm_reg.power_save_select;
			case (pm_reg.power_save_select)
				PWRST_SAVE_FULL:
				begin
					adc_main_enable_out <= 1'b1;
					adc_aux_enable_out  <= 1'b1;
					analog_enable_out   <= 1'b1;
				end
				PWRST_SAVE_COMPOSITE:
				begin
					adc_main_enable_out <= 1'b1;
					adc_aux_enable_out  <= 1'b0;
					analog_enable_out   <= 1'b1;
				end
				PWRST_SAVE_DIGITAL:
				begin
					adc_main_enable_out <= 1'b0;
					adc_aux_enable_out  <= 1'b0;
					analog_enable_out   <= 1'b0;
				end
				default:
				begin
					adc_main_enable_out <= 1'b0;
					adc_aux_enable_out  <= 1'b0;
					analog_enable_out   <= 1'b0;
				end
			endcase
		end
	end

	// Sleep controls
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			reference_sleep_out       <= 1'b0;
			clock_generator_sleep_out <= 1'b0;
		end
		else
		begin
			reference_sleep_out       <= pm_reg.reference_sleep;
			clock_generator_sleep_out <= pm_reg.clock_generator_sleep;
		end
	end

	// Pulses: written bits last one cycle, pin edge gives the same pulse
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			reacquire_out     <= 1'b0;
			core_reset_out    <= 1'b0;
			host_if_reset_out <= 1'b0;
		end
		else
		begin
			reacquire_out     <= pm_reg.timing_reacquire
				|| (rq_sync_reg[1] && !rq_prev_reg);
			core_reset_out    <= pm_reg.core_reset;
			host_if_reset_out <= pm_reg.core_reset;
		end
	end

	// Sticky lost lock; a loss in the read cycle survives the clear
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			lost_lock_reg <= 1'b0;
		else if (lost_event)
			lost_lock_reg <= 1'b1;
		else if (status_rd)
			lost_lock_reg <= 1'b0;
	end

	// Live status sampled every cycle; inputs share this clock
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			status_reg <= pwrst_status_t'(`PWRST_STATUS_RESET);
		else
		begin
			status_reg.in_lock         <= lock_in;
			status_reg.subcarrier_lock <= subcarrier_lock_in;
			status_reg.lost_lock       <= 1'b0;
			status_reg.field_50hz      <= field_50hz_in;
			status_reg.adc_underflow   <= adc_underflow_in;
			status_reg.adc_overflow    <= adc_overflow_in;
			status_reg.white_peak      <= white_peak_in;
			status_reg.colour_kill     <= colour_kill_in;
		end
	end

	// Read data registered; held until the next read strobe
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			reg_rdata_out <= `PWRST_UNMAPPED_READ;
		else if (reg_rd_in)
		begin
			if (reg_addr_in == `PWRST_PM_ADDR)
				reg_rdata_out <= pm_reg;
			else if (reg_addr_in == `PWRST_STATUS_ADDR)
				reg_rdata_out <= status_reg | {6'h00, lost_lock_reg, 1'b0};
			else
				reg_rdata_out <= `PWRST_UNMAPPED_READ;
		end
	end

	pwrst_decimator u_decimator (
		.clock_in        (clock_in),
		.rstn_in         (rstn_in),
		.td_cfg_in       (td_cfg_in),
		.field_start_in  (field_start_in),
		.field_odd_in    (field_odd_in),
		.field_valid_out (field_valid_out)
	);

endmodule // pwrst_regs

// ==== common/pwrst_consts.svh ====
`ifndef PWRST_CONSTS_SVH
`define PWRST_CONSTS_SVH

// Subaddresses
`define PWRST_PM_ADDR          8'h0f
`define PWRST_STATUS_ADDR      8'h10

// Power management field positions
`define PWRST_PM_SAVE_LSB      0
`define PWRST_PM_PRIO_BIT      2
`define PWRST_PM_REF_BIT       3
`define PWRST_PM_CG_BIT        4
`define PWRST_PM_FULLPD_BIT    5
`define PWRST_PM_REACQ_BIT     6
`define PWRST_PM_RESET_BIT     7

// Reset and default values
`define PWRST_PM_RESET         8'h00
`define PWRST_STATUS_RESET     8'h00
`define PWRST_UNMAPPED_READ    8'h00
`define PWRST_SKIP_RESET       4'h0

// Self-clearing bits last this many clock cycles
`define PWRST_SELF_CLEAR_CYCLES 1

`endif

// ==== common/pwrst_pkg.sv ====
package pwrst_pkg;

	typedef enum logic [1:0] {
		PWRST_SAVE_FULL      = 2'h0,
		PWRST_SAVE_COMPOSITE = 2'h1,
		PWRST_SAVE_DIGITAL   = 2'h2,
		PWRST_SAVE_DEEP      = 2'h3
	} pwrst_save_t;

	typedef enum logic [1:0] {
		PWRST_TD_FRAME_EVEN = 2'h0,
		PWRST_TD_FRAME_ODD  = 2'h1,
		PWRST_TD_EVEN_ONLY  = 2'h2,
		PWRST_TD_ODD_ONLY   = 2'h3
	} pwrst_td_pattern_t;

	typedef struct packed {
		logic       core_reset;
		logic       timing_reacquire;
		logic       full_powerdown;
		logic       clock_generator_sleep;
		logic       reference_sleep;
		logic       powerdown_priority;
		pwrst_save_t power_save_select;
	} pwrst_pm_t;

	typedef struct packed {
		logic colour_kill;
		logic white_peak;
		logic adc_overflow;
		logic adc_underflow;
		logic field_50hz;
		logic subcarrier_lock;
		logic lost_lock;
		logic in_lock;
	} pwrst_status_t;

	typedef struct packed {
		logic              enable;
		pwrst_td_pattern_t pattern;
		logic [3:0]        skip_count;
	} pwrst_td_cfg_t;

endpackage

// ==== verilog/pwrst_decimator.sv ====
`timescale 1ns/1ps
`include "pwrst_consts.svh"

module pwrst_decimator
	import pwrst_pkg::*;
(
	input  wire logic          clock_in,        // Core clock
	input  wire logic          rstn_in,         // Async reset, active low
	input  wire pwrst_td_cfg_t td_cfg_in,       // Decimation settings
	input  wire logic          field_start_in,  // Pulse at each field start
	input  wire logic          field_odd_in,    // Parity of the starting field
	output logic               field_valid_out  // Current field is output
);

	logic [3:0] skip_cnt_reg;
	logic       frame_pass_reg;
	logic       odd_target;
	logic       frame_first;

	function automatic logic pass_now(input logic [3:0] cnt, input logic [3:0] skip);
		pass_now = (cnt == skip);
	endfunction

	// Frame modes: first field of a frame has the chosen start parity
	assign frame_first = (field_odd_in == td_cfg_in.pattern[0]);
	assign odd_target  = td_cfg_in.pattern[0];

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			skip_cnt_reg    <= `PWRST_SKIP_RESET;
			frame_pass_reg  <= 1'b1;
			field_valid_out <= 1'b1;
		end
		else if (field_start_in)
		begin
			if (!td_cfg_in.enable)
			begin
				skip_cnt_reg    <= `PWRST_SKIP_RESET;
				frame_pass_reg  <= 1'b1;
				field_valid_out <= 1'b1;
			end
			else if (td_cfg_in.pattern[1])
			begin
				// Fields of the other parity always pass
				if (field_odd_in != odd_target)
					field_valid_out <= 1'b1;
				else if (pass_now(skip_cnt_reg, td_cfg_in.skip_count))
				begin
					skip_cnt_reg    <= `PWRST_SKIP_RESET;
					field_valid_out <= 1'b1;
				end
				else
				begin
					skip_cnt_reg    <= skip_cnt_reg + 4'h1;
					field_valid_out <= 1'b0;
				end
			end
			else if (frame_first)
			begin
				if (pass_now(skip_cnt_reg, td_cfg_in.skip_count))
				begin
					skip_cnt_reg    <= `PWRST_SKIP_RESET;
					frame_pass_reg  <= 1'b1;
					field_valid_out <= 1'b1;
				end
				else
				begin
					skip_cnt_reg    <= skip_cnt_reg + 4'h1;
					frame_pass_reg  <= 1'b0;
					field_valid_out <= 1'b0;
				end
			end
			else
				field_valid_out <= frame_pass_reg; // Second field follows its frame
		end
	end

endmodule // pwrst_decimator

// ==== tb/pwrst_regs_chk.sv ====
`timescale 1ns/1ps
module pwrst_regs_chk (
	input wire logic	clock_in,	// Clock
	input wire logic	rstn_in,	// Reset
	input wire logic [7:0]	reg_addr_in,	// Address
	input wire logic [7:0]	reg_wdata_in,	// Data in
	input wire logic	reg_wr_in,	// Write
	input wire logic	reg_rd_in,	// Read
	input wire logic	lock_in,	// Lock
	input wire logic [7:0]	reg_rdata_out,	// Data out
	input wire logic	adc_main_enable_out,	// Enable
	input wire logic	adc_aux_enable_out,	// Enable
	input wire logic	analog_enable_out,	// Enable
	input wire logic	core_powerdown_out,	// Powerdown
	input wire logic	pads_disable_out,	// Powerdown
	input wire logic	clock_stop_out,	// Powerdown
	input wire logic	reference_sleep_out,	// Sleep
	input wire logic	clock_generator_sleep_out,	// Sleep
	input wire logic	reacquire_out,	// Pulse
	input wire logic	core_reset_out,	// Pulse
	input wire logic	host_if_reset_out	// Pulse
);
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);
	wire pw = reg_wr_in && reg_addr_in == 8'h0f;
	wire sr = reg_rd_in && reg_addr_in == 8'h10;
	// Enables that the mode in the write data should give
	wire [2:0] en_of = reg_wdata_in[1] ? 3'h0 : (reg_wdata_in[0] ? 3'h5 : 3'h7);

	a_mode_enables:
		assert property (pw |-> ##2 {adc_main_enable_out, adc_aux_enable_out,
			analog_enable_out} == $past(en_of, 2)) else $error("mode enables wrong");
	a_bit_powerdown:
		assert property (pw && reg_wdata_in[2] |-> ##2
			core_powerdown_out == $past(reg_wdata_in[5], 2)) else $error("powerdown wrong");
	a_pd_together:
		assert property (core_powerdown_out == pads_disable_out
			&& core_powerdown_out == clock_stop_out) else $error("powerdown split");
	a_sleep_copy:
		assert property (pw |-> ##2 {clock_generator_sleep_out, reference_sleep_out}
			== $past(reg_wdata_in[4:3], 2)) else $error("sleep bits wrong");
	a_reacq_pulse:
		assert property (pw && reg_wdata_in[6] |-> ##2 reacquire_out ##1 !reacquire_out)
			else $error("reacquire pulse wrong");
	a_core_reset:
		assert property (pw && reg_wdata_in[7] |-> ##2 core_reset_out && host_if_reset_out
			##1 !core_reset_out) else $error("reset pulse wrong");
	a_status_lock:
		assert property (sr |=> reg_rdata_out[0] == $past(lock_in, 2))
			else $error("lock bit wrong");
	a_lost_sticky:
		assert property (!lock_in ##1 sr |=> reg_rdata_out[1])
			else $error("lost lock missing");
	cover property (sr);
	cover property (pw && reg_wdata_in[7]);
	cover property (!lock_in ##1 sr);
endmodule // pwrst_regs_chk

bind pwrst_regs pwrst_regs_chk u_chk (.*);

// ==== tb/pwrst_host.sv ====
`timescale 1ns/1ps
module pwrst_host (
	input wire logic	clock_in,	// Clock
	input wire logic [7:0]	rdata_in,	// Read data
	output logic [7:0]	addr_out,	// Address
	output logic [7:0]	wdata_out,	// Write data
	output logic	wr_out,	// Write strobe
	output logic	rd_out	// Read strobe
);
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// Bus lines go to the inverse once released, so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clock_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clock_in);
		rd_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
	endtask
endmodule // pwrst_host

// ==== tb/pwrst_regs_tb.sv ====
`timescale 1ns/1ps
module pwrst_regs_tb
	import pwrst_pkg::*;
;
	logic	clk = 1'b0;
	logic	rstn = 1'b0;
	logic	pin = 1'b0;
	logic	rq_pin = 1'b0;
	logic [7:0]	st = 8'h01;
	pwrst_td_cfg_t	td = '0;
	logic	fs = 1'b0;
	logic	fo = 1'b0;
	logic [7:0]	a, d, rdata, rv;
	logic	wr, rd;
	logic [1:0]	pmode;
	logic [2:0]	en;
	logic	m_en, x_en, an_en, pd, pads, cks, rs, cg, rq, cr, hr, fv;
	int	fail_count = 0;
	int	num_checks = 0;
	int	cycles = 0;

	always #20 clk = ~clk;

	pwrst_regs DUT (.clock_in(clk), .rstn_in(rstn), .reg_addr_in(a), .reg_wdata_in(d),
		.reg_wr_in(wr), .reg_rd_in(rd), .powerdown_pin_in(pin), .reacquire_pin_in(rq_pin),
		.lock_in(st[0]), .subcarrier_lock_in(st[2]), .field_50hz_in(st[3]),
		.adc_underflow_in(st[4]), .adc_overflow_in(st[5]), .white_peak_in(st[6]),
		.colour_kill_in(st[7]), .td_cfg_in(td), .field_start_in(fs), .field_odd_in(fo),
		.reg_rdata_out(rdata), .power_save_select_out(pmode), .adc_main_enable_out(m_en),
		.adc_aux_enable_out(x_en), .analog_enable_out(an_en), .core_powerdown_out(pd),
		.pads_disable_out(pads), .clock_stop_out(cks), .reference_sleep_out(rs),
		.clock_generator_sleep_out(cg), .reacquire_out(rq), .core_reset_out(cr),
		.host_if_reset_out(hr), .field_valid_out(fv));
	pwrst_host host (.clock_in(clk), .rdata_in(rdata), .addr_out(a), .wdata_out(d),
		.wr_out(wr), .rd_out(rd));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++)
		begin
			host.wr(8'h0f, 8'(m));
			@(negedge clk);
			en = m[1] ? 3'h0 : (m[0] ? 3'h5 : 3'h7);
			check({m_en, x_en, an_en, pmode}, {en, 2'(m)});
			host.rd(8'h0f, rv);
			check(rv, 8'(m));
		end
	endtask
	task automatic t_power;
		pin = 1'b1;
		host.wr(8'h0f, 8'h1c);
		repeat (4) @(negedge clk);
		check({pd, rs, cg}, 3'h3);
		host.wr(8'h0f, 8'h24);
		@(negedge clk);
		check({pd, pads, cks, rs, cg}, 5'h1c);
		host.wr(8'h0f, 8'h00);
		repeat (4) @(negedge clk);
		check(8'(pd), 8'h01);
		pin = 1'b0;
		repeat (5) @(negedge clk);
		check(8'(pd), 8'h00);
	endtask
	task automatic t_pulse;
		host.wr(8'h0f, 8'hc0);
		check({rq, cr, hr}, 3'h0);
		@(negedge clk);
		check({rq, cr, hr}, 3'h7);
		@(negedge clk);
		check({rq, cr, hr}, 3'h0);
		host.rd(8'h0f, rv);
		check(rv, 8'h00);
		// Pin edge needs two sync flops and the reacquire_out flop before the pulse shows
		rq_pin = 1'b1;
		repeat (2) @(negedge clk);
		check(8'(rq), 8'h00);
		@(negedge clk);
		check(8'(rq), 8'h01);
		@(negedge clk);
		check(8'(rq), 8'h00);
		rq_pin = 1'b0;
	endtask
	task automatic t_status;
		st = 8'ha5;
		repeat (3) @(negedge clk);
		host.rd(8'h10, rv);
		check(rv, 8'ha5);
		st = 8'h5c;
		repeat (3) @(negedge clk);
		// Lock still low at this read edge, so the sticky bit must survive it
		host.rd(8'h10, rv);
		check(rv, 8'h5e);
		st = 8'h5d;
		repeat (3) @(negedge clk);
		host.rd(8'h10, rv);
		check(rv, 8'h5f);
		host.wr(8'h10, 8'hff);
		host.rd(8'h10, rv);
		check(rv, 8'h5d);
		host.rd(8'h11, rv);
		check(rv, 8'h00);
	endtask
	task automatic field(input logic odd, input logic exp);
		@(negedge clk);
		fs = 1'b1;
		fo = odd;
		@(negedge clk);
		fs = 1'b0;
		check(8'(fv), 8'(exp));
	endtask
	task automatic t_decim;
		td = '{1'b1, PWRST_TD_EVEN_ONLY, 4'h2};
		for (int i = 0; i < 6; i++)
			field(1'b0, i % 3 == 2);
		field(1'b1, 1'b1);
		td.enable = 1'b0;
		field(1'b0, 1'b1);
		td = '{1'b1, PWRST_TD_FRAME_ODD, 4'h1};
		for (int i = 0; i < 8; i++)
			field(i % 2 == 0, (i / 2) % 2 == 1);
		td.pattern = PWRST_TD_ODD_ONLY;
		field(1'b1, 1'b0);
		field(1'b0, 1'b1);
		field(1'b1, 1'b1);
	endtask

	initial
	begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_modes();
		t_power();
		t_pulse();
		t_status();
		t_decim();
		results();
	end
	// The whole run needs about 110 cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			results();
		end
	end
endmodule // pwrst_regs_tb
